// ---- verilog/tptd_consts.svh ----
// Constants for the pointer, counter and stack transfer decoder
`ifndef TPTD_CONSTS_SVH
`define TPTD_CONSTS_SVH

// ----------------------------------------------------------------
// Opcode encodings
// ----------------------------------------------------------------
`define TPTD_OP_LOAD 8'h6A
`define TPTD_OP_STORE 8'h69
`define TPTD_GROUP_PREFIX 4'hF

// ----------------------------------------------------------------
// Selector encodings (low nibble of the second byte)
// ----------------------------------------------------------------
`define TPTD_SEL_PTR_LO 4'hC
`define TPTD_SEL_PTR_MID 4'hD
`define TPTD_SEL_PTR_HI 4'hE
`define TPTD_SEL_CNT1_LO 4'h4
`define TPTD_SEL_CNT1_MID 4'h5
`define TPTD_SEL_CNT1_HI 4'h6
`define TPTD_SEL_CNT2_LO 4'h8
`define TPTD_SEL_CNT2_MID 4'h9
`define TPTD_SEL_CNT2_HI 4'hA
`define TPTD_SEL_STACK 4'hF

// ----------------------------------------------------------------
// Field positions, sizes and reset values
// ----------------------------------------------------------------
`define TPTD_NIB_LO 2'h0
`define TPTD_NIB_MID 2'h1
`define TPTD_NIB_HI 2'h2
`define TPTD_PREFIX_MSB 7
`define TPTD_PREFIX_LSB 4
`define TPTD_SEL_MSB 3
`define TPTD_SEL_LSB 0
`define TPTD_INSTR_BYTES 2
`define TPTD_INSTR_CYCLES 2
`define TPTD_WIDE_RESET 12'h000
`define TPTD_NIB_RESET 4'h0
`define TPTD_STATUS_SET 1'b1

`endif

// ---- verilog/tptd_pkg.sv ----
// Types shared by the transfer decoder files
`default_nettype none

package tptd_pkg;

    // Two-byte sequence; Gray along fetch-op -> fetch-selector -> fetch-op
    typedef enum logic [1:0]
    {
        TPTD_FETCH_OP = 2'b00,
        TPTD_FETCH_SEL = 2'b01
    } tptd_state_t;

    typedef enum logic [1:0]
    {
        TPTD_TGT_PTR = 2'b00,
        TPTD_TGT_CNT1 = 2'b01,
        TPTD_TGT_CNT2 = 2'b10,
        TPTD_TGT_STACK = 2'b11
    } tptd_target_t;

    typedef logic [1:0] tptd_nib_t;

endpackage

`default_nettype wire

// ---- verilog/tptd_nibble_reg.sv ----
// Twelve-bit register written one nibble at a time
`default_nettype none
`include "tptd_consts.svh"

module tptd_nibble_reg
    import tptd_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Nibble write
    input wire logic wrEn,
    input wire tptd_nib_t wrSel,
    input wire logic [3:0] wrData,
    // Whole value
    output logic [11:0] value
);

    logic [3:0] nib_q [3];
    logic [3:0] nib_d [3];

    // ----------------------------------------------------------------
    // Per-nibble storage
    // ----------------------------------------------------------------
    for (genvar g = 0; g < 3; g++)
    begin : gen_nib
        always_comb
        begin
            nib_d[g] = nib_q[g];
            if (wrEn && (wrSel == tptd_nib_t'(g)))
            begin
                nib_d[g] = wrData; // RULE_09
            end
        end

        always_ff @(posedge clk)
        begin
            if (!rst_n)
            begin
                nib_q[g] <= `TPTD_NIB_RESET;
            end
            else
            begin
                nib_q[g] <= nib_d[g];
            end
        end

        assign value[g*4 +: 4] = nib_q[g];
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    chk_nibble_keep_lo: assert property (@(posedge clk) disable iff (!rst_n) // RULE_09
        (wrEn && wrSel != `TPTD_NIB_LO) |=> (value[3:0] == $past(value[3:0])))
        else $error("Low nibble changed on a write to another nibble");

endmodule

`default_nettype wire

// ---- verilog/tptd_transfer_decode.sv ----
// Decode and execute of accumulator transfers to pointer, counters and stack
// Function
// RULE_01 - Byte one 6A with selector prefix F decodes a load into accumulator
// RULE_02 - Byte one 69 with selector prefix F stores accumulator into target nibble
// RULE_03 - Selectors C, D, E reach low, middle, high data pointer nibbles
// RULE_04 - Selectors 4, 5, 6 reach low, middle, high counter one nibbles
// RULE_05 - Selectors 8, 9, A reach low, middle, high counter two nibbles
// RULE_06 - Selector F moves the whole stack index to or from accumulator
// RULE_07 - Every transfer takes two bytes and two instruction cycles
// RULE_08 - Loads update zero flag, stores keep it; carry untouched; status set
// RULE_09 - A counter nibble store leaves the other two nibbles unchanged
`default_nettype none
`include "tptd_consts.svh"

module tptd_transfer_decode
    import tptd_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Program byte stream, one byte per instruction cycle
    input wire logic codeValid,
    input wire logic [7:0] codeByte,
    // Accumulator
    input wire logic [3:0] accIn,
    output logic accLoad,
    output logic [3:0] accData,
    // Flags
    output logic zeroFlagLoad,
    output logic zeroFlagData,
    output logic statusFlagSet,
    // Sequence status
    output logic instrBusy,
    output logic instrDone,
    output logic selectorReject,
    // Register contents
    output logic [11:0] dataPointerReg,
    output logic [11:0] counterOneReg,
    output logic [11:0] counterTwoReg,
    output logic [3:0] stackIndexReg
);

    tptd_state_t state_q, state_d;
    logic isStore_q, isStore_d;
    logic accLoad_q, accLoad_d;
    logic [3:0] accData_q, accData_d;
    logic zeroLoad_q, zeroLoad_d;
    logic zeroData_q, zeroData_d;
    logic statusSet_q, statusSet_d;
    logic done_q, done_d;
    logic reject_q, reject_d;
    logic [3:0] stack_q, stack_d;

    logic [3:0] selCode;
    logic prefixOk;
    logic selValid;
    tptd_target_t target;
    tptd_nib_t nibSel;
    logic [3:0] readNib;
    logic execute;
    logic ptrWr, cnt1Wr, cnt2Wr;

    // ----------------------------------------------------------------
    // Selector decode
    // ----------------------------------------------------------------
    assign selCode = codeByte[`TPTD_SEL_MSB:`TPTD_SEL_LSB];
    assign prefixOk = (codeByte[`TPTD_PREFIX_MSB:`TPTD_PREFIX_LSB] == `TPTD_GROUP_PREFIX);

    always_comb
    begin
        selValid = 1'b1;
        target = TPTD_TGT_PTR;
        nibSel = `TPTD_NIB_LO;
        unique case (selCode)
            `TPTD_SEL_PTR_LO, `TPTD_SEL_PTR_MID, `TPTD_SEL_PTR_HI:
                target = TPTD_TGT_PTR; // RULE_03
            `TPTD_SEL_CNT1_LO, `TPTD_SEL_CNT1_MID, `TPTD_SEL_CNT1_HI:
                target = TPTD_TGT_CNT1; // RULE_04
            `TPTD_SEL_CNT2_LO, `TPTD_SEL_CNT2_MID, `TPTD_SEL_CNT2_HI:
                target = TPTD_TGT_CNT2; // RULE_05
            `TPTD_SEL_STACK: target = TPTD_TGT_STACK; // RULE_06
            // Codes 0-3, 7 and B have no target in this group
            default: selValid = 1'b0;
        endcase
        // Nibble position is shared by all three wide registers
        unique case (selCode)
            `TPTD_SEL_PTR_MID, `TPTD_SEL_CNT1_MID, `TPTD_SEL_CNT2_MID: nibSel = `TPTD_NIB_MID;
            `TPTD_SEL_PTR_HI, `TPTD_SEL_CNT1_HI, `TPTD_SEL_CNT2_HI: nibSel = `TPTD_NIB_HI;
            default: nibSel = `TPTD_NIB_LO;
        endcase
    end

    // Read side: nibble of the addressed register
    always_comb
    begin
        unique case (target)
            TPTD_TGT_PTR: readNib = dataPointerReg[nibSel*4 +: 4];
            TPTD_TGT_CNT1: readNib = counterOneReg[nibSel*4 +: 4];
            TPTD_TGT_CNT2: readNib = counterTwoReg[nibSel*4 +: 4];
            TPTD_TGT_STACK: readNib = stack_q;
        endcase
    end

    // ----------------------------------------------------------------
    // Two-byte sequencer and execute
    // ----------------------------------------------------------------
    assign execute = (state_q == TPTD_FETCH_SEL) && codeValid && prefixOk && selValid;
    assign ptrWr = execute && isStore_q && (target == TPTD_TGT_PTR); // RULE_02
    assign cnt1Wr = execute && isStore_q && (target == TPTD_TGT_CNT1); // RULE_02
    assign cnt2Wr = execute && isStore_q && (target == TPTD_TGT_CNT2); // RULE_02

    always_comb
    begin
        state_d = state_q;
        isStore_d = isStore_q;
        accLoad_d = 1'b0;
        accData_d = accData_q;
        zeroLoad_d = 1'b0;
        zeroData_d = zeroData_q;
        statusSet_d = 1'b0;
        done_d = 1'b0;
        reject_d = 1'b0;
        stack_d = stack_q;
        unique case (state_q)
            TPTD_FETCH_OP:
            begin
                // Other first bytes belong to other groups and are ignored here
                if (codeValid && (codeByte == `TPTD_OP_LOAD || codeByte == `TPTD_OP_STORE))
                begin
                    state_d = TPTD_FETCH_SEL; // RULE_07
                    isStore_d = (codeByte == `TPTD_OP_STORE);
                end
            end
            TPTD_FETCH_SEL:
            begin
                if (codeValid)
                begin
                    state_d = TPTD_FETCH_OP;
                    if (execute)
                    begin
                        done_d = 1'b1; // RULE_07
                        statusSet_d = `TPTD_STATUS_SET; // RULE_08
                        if (isStore_q)
                        begin
                            if (target == TPTD_TGT_STACK)
                            begin
                                stack_d = accIn; // RULE_06
                            end
                        end
                        else
                        begin
                            accLoad_d = 1'b1; // RULE_01
                            accData_d = readNib; // RULE_01
                            zeroLoad_d = 1'b1; // RULE_08
                            zeroData_d = (readNib == `TPTD_NIB_RESET); // RULE_08
                        end
                    end
                    else
                    begin
                        reject_d = 1'b1;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            state_q <= TPTD_FETCH_OP;
            isStore_q <= 1'b0;
            accLoad_q <= 1'b0;
            accData_q <= `TPTD_NIB_RESET;
            zeroLoad_q <= 1'b0;
            zeroData_q <= 1'b0;
            statusSet_q <= 1'b0;
            done_q <= 1'b0;
            reject_q <= 1'b0;
            stack_q <= `TPTD_NIB_RESET;
        end
        else
        begin
            state_q <= state_d;
            isStore_q <= isStore_d;
            accLoad_q <= accLoad_d;
            accData_q <= accData_d;
            zeroLoad_q <= zeroLoad_d;
            zeroData_q <= zeroData_d;
            statusSet_q <= statusSet_d;
            done_q <= done_d;
            reject_q <= reject_d;
            stack_q <= stack_d;
        end
    end

    // ----------------------------------------------------------------
    // Nibble-addressed registers
    // ----------------------------------------------------------------
    tptd_nibble_reg u_pointer
    (
        .clk(clk),
        .rst_n(rst_n),
        .wrEn(ptrWr),
        .wrSel(nibSel),
        .wrData(accIn),
        .value(dataPointerReg)
    );

    tptd_nibble_reg u_counter_one
    (
        .clk(clk),
        .rst_n(rst_n),
        .wrEn(cnt1Wr),
        .wrSel(nibSel),
        .wrData(accIn),
        .value(counterOneReg)
    );

    tptd_nibble_reg u_counter_two
    (
        .clk(clk),
        .rst_n(rst_n),
        .wrEn(cnt2Wr),
        .wrSel(nibSel),
        .wrData(accIn),
        .value(counterTwoReg)
    );

    // Carry is never driven: the flag stays with the core untouched
    assign accLoad = accLoad_q;
    assign accData = accData_q;
    assign zeroFlagLoad = zeroLoad_q;
    assign zeroFlagData = zeroData_q;
    assign statusFlagSet = statusSet_q;
    assign instrBusy = (state_q == TPTD_FETCH_SEL);
    assign instrDone = done_q;
    assign selectorReject = reject_q;
    assign stackIndexReg = stack_q;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    chk_load_ptr_low: assert property ( // RULE_01
        (state_q == TPTD_FETCH_SEL && codeValid && !isStore_q
            && codeByte == {`TPTD_GROUP_PREFIX, `TPTD_SEL_PTR_LO})
        |=> (accLoad && accData == $past(dataPointerReg[3:0])))
        else $error("Load of pointer low nibble not delivered");

    chk_store_ptr_high: assert property ( // RULE_03
        (state_q == TPTD_FETCH_SEL && codeValid && isStore_q
            && codeByte == {`TPTD_GROUP_PREFIX, `TPTD_SEL_PTR_HI})
        |=> (dataPointerReg[11:8] == $past(accIn) && !accLoad))
        else $error("Store to pointer high nibble missed");

    chk_cnt1_mid_load: assert property ( // RULE_04
        (state_q == TPTD_FETCH_SEL && codeValid && !isStore_q
            && codeByte == {`TPTD_GROUP_PREFIX, `TPTD_SEL_CNT1_MID})
        |=> (accData == $past(counterOneReg[7:4])))
        else $error("Load of counter one middle nibble wrong");

    chk_cnt2_high_store: assert property ( // RULE_05
        (state_q == TPTD_FETCH_SEL && codeValid && isStore_q
            && codeByte == {`TPTD_GROUP_PREFIX, `TPTD_SEL_CNT2_HI})
        |=> (counterTwoReg[11:8] == $past(accIn)
            && counterTwoReg[7:0] == $past(counterTwoReg[7:0])))
        else $error("Store to counter two high nibble wrong");

    chk_stack_store: assert property ( // RULE_06
        (state_q == TPTD_FETCH_SEL && codeValid && isStore_q
            && codeByte == {`TPTD_GROUP_PREFIX, `TPTD_SEL_STACK})
        |=> (stackIndexReg == $past(accIn)))
        else $error("Stack index store missed");

    chk_two_cycle_done: assert property ( // RULE_07
        (state_q == TPTD_FETCH_OP && codeValid && codeByte == `TPTD_OP_STORE)
        ##1 (codeValid && prefixOk && selValid)
        |=> (instrDone && !instrBusy))
        else $error("Transfer did not finish on the second cycle");

    chk_load_flags: assert property ( // RULE_08
        accLoad |-> (zeroFlagLoad && zeroFlagData == (accData == `TPTD_NIB_RESET) && statusFlagSet))
        else $error("Load flag update wrong");

    chk_store_flags: assert property ( // RULE_08
        (instrDone && !accLoad) |-> (!zeroFlagLoad && statusFlagSet))
        else $error("Store touched the zero flag or missed status");

endmodule

`default_nettype wire

// ---- verification/timer_pointer_transfer_decode_test.sv ----
// Self-checking bench for the accumulator transfer decoder
`default_nettype none

module timer_pointer_transfer_decode_test;
    timeunit 1ns;
    timeprecision 100ps;

    // ------------------------------------------------------------
    // Stimulus and design outputs
    // ------------------------------------------------------------
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic codeValid = 1'b0;
    logic [7:0] codeByte = 8'h00;
    logic [3:0] accIn = 4'h0;
    logic accLoad, zeroFlagLoad, zeroFlagData, statusFlagSet;
    logic instrBusy, instrDone, selectorReject;
    logic [3:0] accData, stackIndexReg;
    logic [11:0] dataPointerReg, counterOneReg, counterTwoReg;
    // Reference state kept by the bench
    logic [11:0] dpM, c1M, c2M;
    logic [3:0] spM, accM;
    logic zM;
    int fail_count = 0;
    int compares = 0;
    int cycleCount = 0;

    always #2 clk = ~clk;

    tptd_transfer_decode DUT (
        .clk(clk), .rst_n(rst_n), .codeValid(codeValid), .codeByte(codeByte),
        .accIn(accIn), .accLoad(accLoad), .accData(accData),
        .zeroFlagLoad(zeroFlagLoad), .zeroFlagData(zeroFlagData),
        .statusFlagSet(statusFlagSet), .instrBusy(instrBusy), .instrDone(instrDone),
        .selectorReject(selectorReject), .dataPointerReg(dataPointerReg),
        .counterOneReg(counterOneReg), .counterTwoReg(counterTwoReg),
        .stackIndexReg(stackIndexReg)
    );

    // ------------------------------------------------------------
    // Checking and reference helpers
    // ------------------------------------------------------------
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Whole run needs under 2000 cycles
    always @(posedge clk)
    begin
        cycleCount++;
        if (cycleCount == 5000)
        begin
            fail_count++;
            $display("BAD timeout expected done seen hang");
            end_of_test();
        end
    end

    task automatic check(input string what, input logic [11:0] exp, input logic [11:0] got);
        compares++;
        if (got !== exp)
        begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    function automatic logic legal(input logic [3:0] sel);
        return sel inside {4'hC, 4'hD, 4'hE, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9, 4'hA, 4'hF};
    endfunction

    function automatic logic [3:0] pick(input logic [3:0] sel);
        case (sel)
            4'hC: return dpM[3:0];
            4'hD: return dpM[7:4];
            4'hE: return dpM[11:8];
            4'h4: return c1M[3:0];
            4'h5: return c1M[7:4];
            4'h6: return c1M[11:8];
            4'h8: return c2M[3:0];
            4'h9: return c2M[7:4];
            4'hA: return c2M[11:8];
            default: return spM;
        endcase
    endfunction

    task automatic put(input logic [3:0] sel, input logic [3:0] v);
        case (sel)
            4'hC: dpM[3:0] = v;
            4'hD: dpM[7:4] = v;
            4'hE: dpM[11:8] = v;
            4'h4: c1M[3:0] = v;
            4'h5: c1M[7:4] = v;
            4'h6: c1M[11:8] = v;
            4'h8: c2M[3:0] = v;
            4'h9: c2M[7:4] = v;
            4'hA: c2M[11:8] = v;
            4'hF: spM = v;
            default: ;
        endcase
    endtask

    task automatic checkRegs();
        check("pointer", dpM, dataPointerReg);
        check("counter one", c1M, counterOneReg);
        check("counter two", c2M, counterTwoReg);
        check("stack index", 12'(spM), 12'(stackIndexReg));
        check("acc data", 12'(accM), 12'(accData));
        check("zero data", 12'(zM), 12'(zeroFlagData));
    endtask

    // ------------------------------------------------------------
    // Drivers
    // ------------------------------------------------------------
    task automatic doReset();
        rst_n = 1'b0;
        codeValid = 1'b0;
        repeat (3) @(posedge clk);
        #1;
        rst_n = 1'b1;
        {dpM, c1M, c2M, spM, accM, zM} = '0;
        check("busy after reset", 12'h000, 12'(instrBusy));
        check("pulses after reset", 12'h000,
              12'({accLoad, zeroFlagLoad, statusFlagSet, instrDone, selectorReject}));
        checkRegs();
    endtask

    // Caller follows with another run or with idle, so no signal is driven twice
    task automatic run(input logic isLoad, input logic [7:0] second, input logic [3:0] acc,
                       input int gap);
        logic ok;
        logic [3:0] exp;
        ok = (second[7:4] == 4'hF) && legal(second[3:0]);
        codeValid = 1'b1;
        codeByte = isLoad ? 8'h6A : 8'h69;
        @(posedge clk);
        #1;
        check("busy after first byte", 12'h001, 12'(instrBusy));
        check("pulses one cycle", 12'h000,
              12'({accLoad, zeroFlagLoad, statusFlagSet, instrDone, selectorReject}));
        repeat (gap)
        begin
            codeValid = 1'b0;
            @(posedge clk);
            #1;
            check("busy while waiting", 12'h001, 12'(instrBusy));
        end
        codeValid = 1'b1;
        codeByte = second;
        accIn = acc;
        @(posedge clk);
        #1;
        exp = pick(second[3:0]);
        if (ok && !isLoad)
            put(second[3:0], acc);
        if (ok && isLoad)
        begin
            accM = exp;
            zM = (exp == 4'h0);
        end
        check("done", 12'(ok), 12'(instrDone));
        check("reject", 12'(!ok), 12'(selectorReject));
        check("status set", 12'(ok), 12'(statusFlagSet));
        check("acc load", 12'(ok && isLoad), 12'(accLoad));
        check("zero load", 12'(ok && isLoad), 12'(zeroFlagLoad));
        check("busy after second byte", 12'h000, 12'(instrBusy));
        checkRegs();
    endtask

    task automatic idle(input int n);
        codeValid = 1'b0;
        codeByte = 8'(~codeByte);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        logic [7:0] b;
        void'($urandom(32'h1d11));
        doReset();
        $display("test reset done");
        // Store then load back every selector, acc values 0 and F included
        for (int s = 0; s < 16; s++)
        begin
            run(1'b0, {4'hF, 4'(s)}, 4'(s ^ 10), 0);
            run(1'b1, {4'hF, 4'(s)}, 4'h0, s % 3);
        end
        $display("test selector sweep done");
        // Wrong prefix, including a first-byte value in the second slot
        run(1'b1, 8'h7C, 4'h3, 0);
        run(1'b0, 8'h69, 4'h3, 1);
        run(1'b0, 8'hE5, 4'h3, 0);
        idle(1);
        $display("test prefix reject done");
        // Unrelated opcodes in idle must not start a transfer
        for (int i = 0; i < 20; i++)
        begin
            b = 8'($urandom);
            if (b == 8'h6A || b == 8'h69)
                b = 8'h00;
            codeValid = 1'b1;
            codeByte = b;
            @(posedge clk);
            #1;
            check("busy on other opcode", 12'h000, 12'(instrBusy));
            check("done on other opcode", 12'h000, 12'(instrDone));
        end
        idle(1);
        $display("test foreign opcodes done");
        for (int i = 0; i < 300; i++)
        begin
            b = {(($urandom % 8) == 0) ? 4'($urandom) : 4'hF, 4'($urandom)};
            run(1'($urandom), b, 4'($urandom), (($urandom % 4) == 0) ? 1 : 0);
            if (($urandom % 5) == 0)
                idle(1);
        end
        $display("test random mix done");
        // Reset in the middle of an instruction
        codeValid = 1'b1;
        codeByte = 8'h69;
        @(posedge clk);
        #1;
        doReset();
        run(1'b1, 8'hF5, 4'h1, 0);
        idle(2);
        $display("test reset mid instruction done");
        end_of_test();
    end

endmodule

`default_nettype wire
